// ===== hdl/amc_alarm_mask_top.sv
// Functional notes
// - Four-bit current scale, reset all ones
// - FIFO error zeroes receive data when enabled
// - Software bit forces the tx_gate output high
// - Forty-eight suppression bits, one means suppressed
// - Low register upper byte: lane errors
// - Low register lower byte: lane FIFO flags
// - Mid bits 15:12 suppress link SYSREF errors
// - Mid bits 11:8 suppress PA protection
// - Mid bits 3:2 suppress receiver PLL lock
// - Mid bit 1 suppresses SYSREF timing alarm
// - Mid bit 0 suppresses converter PLL lock
// - High upper byte: short test alarms
// - High lower byte: loss of signal
// - Register-reset bit restores defaults, self clears
`timescale 1ns/100ps
`default_nettype none

module amc_alarm_mask_top #(
	parameter int DATA_W = 64,
	parameter int LANES = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Serial control pins
	input wire logic sif_clk,
	input wire logic sif_sdi,
	input wire logic sif_en_n,
	output logic sif_sdo,
	output logic sif_sdo_oe,
	// Transmit enable pin and gate
	input wire logic tx_enable_pin,
	output logic tx_gate,
	// Receive datapath
	input wire logic [DATA_W-1:0] sample_in,
	input wire logic [LANES-1:0] lane_fifo_error,
	output logic [DATA_W-1:0] sample_out,
	// Analog control
	output logic [3:0] current_scale,
	// Alarms
	input wire logic [47:0] alarm_in,
	output logic [47:0] alarm_reported,
	output logic alarm_out
);

	// ----------------------------------------------------------------
	// Serial port
	// ----------------------------------------------------------------
	amc_reg_if bus ();

	amc_serial_port u_port (
		.ref_clk(ref_clk),
		.reset(reset),
		.sif_clk(sif_clk),
		.sif_sdi(sif_sdi),
		.sif_en_n(sif_en_n),
		.sif_sdo(sif_sdo),
		.sif_sdo_oe(sif_sdo_oe),
		.bus(bus)
	);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [15:0] output_control;
	logic [15:0] alarm_suppress_low;
	logic [15:0] alarm_suppress_mid;
	logic [15:0] alarm_suppress_high;
	logic reg_reset_bit;
	logic soft_reset;

	// self-clearing register reset
	// Each accepted write of one is a rising transition because the bit
	// has already cleared itself; defaults load on the following cycle.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_reset_bit <= 1'b0;
		end else begin
			reg_reset_bit <= bus.wr_stb && bus.addr == amc_pkg::ADDR_REG_RESET
				&& bus.wdata[amc_pkg::REG_RESET_BIT] && !reg_reset_bit;
		end
	end
	assign soft_reset = reg_reset_bit;
	// The serial port is not reset here, so the frame carrying the write still ends cleanly.

	logic wr_ctl;
	logic wr_low;
	logic wr_mid;
	logic wr_high;
	assign wr_ctl = bus.wr_stb && bus.addr == amc_pkg::ADDR_OUTPUT_CONTROL;
	assign wr_low = bus.wr_stb && bus.addr == amc_pkg::ADDR_ALARM_SUPPRESS_LOW;
	assign wr_mid = bus.wr_stb && bus.addr == amc_pkg::ADDR_ALARM_SUPPRESS_MID;
	assign wr_high = bus.wr_stb && bus.addr == amc_pkg::ADDR_ALARM_SUPPRESS_HIGH;

	always_ff @(posedge ref_clk) begin
		if (reset || soft_reset) begin
			output_control <= amc_pkg::RST_OUTPUT_CONTROL;
		end else if (wr_ctl) begin
			output_control <= (bus.wdata & amc_pkg::OUTPUT_CONTROL_WMASK)
				| (amc_pkg::RST_OUTPUT_CONTROL & ~amc_pkg::OUTPUT_CONTROL_WMASK);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || soft_reset) begin
			alarm_suppress_low <= amc_pkg::RST_ALARM_SUPPRESS_LOW;
		end else if (wr_low) begin
			alarm_suppress_low <= bus.wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || soft_reset) begin
			alarm_suppress_mid <= amc_pkg::RST_ALARM_SUPPRESS_MID;
		end else if (wr_mid) begin
			alarm_suppress_mid <= (bus.wdata & amc_pkg::ALARM_SUPPRESS_MID_WMASK)
				| (amc_pkg::RST_ALARM_SUPPRESS_MID & ~amc_pkg::ALARM_SUPPRESS_MID_WMASK);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || soft_reset) begin
			alarm_suppress_high <= amc_pkg::RST_ALARM_SUPPRESS_HIGH;
		end else if (wr_high) begin
			alarm_suppress_high <= bus.wdata;
		end
	end

	// Unmapped addresses read as zero.
	// The address is latched after the header, so read data settles before the first fall.
	always_comb begin
		case (bus.addr)
			amc_pkg::ADDR_REG_RESET: bus.rdata = {15'h0000, reg_reset_bit};
			amc_pkg::ADDR_OUTPUT_CONTROL: bus.rdata = output_control;
			amc_pkg::ADDR_ALARM_SUPPRESS_LOW: bus.rdata = alarm_suppress_low;
			amc_pkg::ADDR_ALARM_SUPPRESS_MID: bus.rdata = alarm_suppress_mid;
			amc_pkg::ADDR_ALARM_SUPPRESS_HIGH: bus.rdata = alarm_suppress_high;
			default: bus.rdata = 16'h0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Output control
	// ----------------------------------------------------------------
	// current scale field
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			current_scale <= amc_pkg::RST_OUTPUT_CONTROL[15:12];
		end else begin
			current_scale <= output_control[amc_pkg::CURRENT_SCALE_MSB:amc_pkg::CURRENT_SCALE_LSB];
		end
	end

	// The enable pin is asynchronous, so it passes two flops before use.
	logic [1:0] tx_sync;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_sync <= 2'h0;
		end else begin
			tx_sync <= {tx_sync[0], tx_enable_pin};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_gate <= 1'b0;
		end else begin
			tx_gate <= tx_sync[1] | output_control[amc_pkg::SW_TX_ENABLE_BIT];
		end
	end

	// Lane FIFO errors come from this clock, so they need no synchroniser.
	// blank data on FIFO error
	// Blanking is registered together with the data, so the zeroed word
	// lines up with the sample that saw the error.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sample_out <= '0;
		end else if (output_control[amc_pkg::FIFO_ERR_BLANK_BIT] && |lane_fifo_error) begin
			sample_out <= '0;
		end else begin
			sample_out <= sample_in;
		end
	end

	// ----------------------------------------------------------------
	// Alarm merging
	// ----------------------------------------------------------------
	logic [47:0] suppress;
	assign suppress = {alarm_suppress_high, alarm_suppress_mid, alarm_suppress_low};

	// only reporting is gated
	// Detection upstream is untouched; masking acts on the report alone.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			alarm_reported <= 48'h000000000000;
			alarm_out <= 1'b0;
		end else begin
			alarm_reported <= alarm_in & ~suppress;
			alarm_out <= |(alarm_in & ~suppress);
		end
	end

	// Suppression bit n gates alarm_in[n]. In the middle register,
	// alarm_in[31:28] are links 3..0, [27:24] pa_protection A..D,
	// [19:18] receiver PLL 0 and 1, [17] SYSREF timing, [16] converter PLL.
	// In the low register, [15:8] are lane errors and [7:0] FIFO flags, lanes 7..0.
	// In the high register, [47:40] are short tests and [39:32] loss of signal, lanes 7..0.

endmodule : amc_alarm_mask_top

`default_nettype wire

// ===== inc/amc_pkg.sv
`default_nettype none

package amc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam int REG_W = 16;
	localparam logic [6:0] ADDR_REG_RESET = 7'h02;
	localparam logic [6:0] ADDR_OUTPUT_CONTROL = 7'h03;
	localparam logic [6:0] ADDR_ALARM_SUPPRESS_LOW = 7'h04;
	localparam logic [6:0] ADDR_ALARM_SUPPRESS_MID = 7'h05;
	localparam logic [6:0] ADDR_ALARM_SUPPRESS_HIGH = 7'h06;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_OUTPUT_CONTROL = 16'hF380;
	localparam logic [15:0] RST_ALARM_SUPPRESS_LOW = 16'h00FF;
	localparam logic [15:0] RST_ALARM_SUPPRESS_MID = 16'hFFFF;
	localparam logic [15:0] RST_ALARM_SUPPRESS_HIGH = 16'hFFFF;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CURRENT_SCALE_MSB = 15;
	localparam int CURRENT_SCALE_LSB = 12;
	localparam int FIFO_ERR_BLANK_BIT = 7;
	localparam int SW_TX_ENABLE_BIT = 0;
	localparam int REG_RESET_BIT = 0;
	// Writable bits of output control; the rest are reserved.
	localparam logic [15:0] OUTPUT_CONTROL_WMASK = 16'hF081;
	// Bits 7:4 of the middle suppression register are reserved.
	localparam logic [15:0] ALARM_SUPPRESS_MID_WMASK = 16'hFF0F;
	localparam int ALARM_W = 48;

	// ----------------------------------------------------------------
	// Serial frame: read flag, 7 address bits, 16 data bits
	// ----------------------------------------------------------------
	localparam logic [4:0] FRAME_BITS = 5'h18;
	localparam logic [4:0] HEADER_BITS = 5'h08;

endpackage : amc_pkg

`default_nettype wire

// ===== inc/amc_reg_if.sv
`timescale 1ns/100ps
`default_nettype none

interface amc_reg_if;
	logic wr_stb;
	logic [6:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;

	modport port (
		output wr_stb,
		output addr,
		output wdata,
		input rdata
	);

	modport regs (
		input wr_stb,
		input addr,
		input wdata,
		output rdata
	);
endinterface : amc_reg_if

`default_nettype wire

// ===== hdl/amc_serial_port.sv
`timescale 1ns/100ps
`default_nettype none

module amc_serial_port (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Serial control pins
	input wire logic sif_clk,
	input wire logic sif_sdi,
	input wire logic sif_en_n,
	output logic sif_sdo,
	output logic sif_sdo_oe,
	// Register side
	amc_reg_if.port bus
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// The serial clock is oversampled, so it must run well below a
	// quarter of ref_clk for every edge to be seen.
	logic [1:0] clk_sync;
	logic [1:0] sdi_sync;
	logic [1:0] en_sync;
	logic clk_hist;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			clk_sync <= 2'h0;
			sdi_sync <= 2'h0;
			en_sync <= 2'h3;
			clk_hist <= 1'b0;
		end else begin
			clk_sync <= {clk_sync[0], sif_clk};
			sdi_sync <= {sdi_sync[0], sif_sdi};
			en_sync <= {en_sync[0], sif_en_n};
			clk_hist <= clk_sync[1];
		end
	end

	logic active;
	logic rise;
	logic fall;
	assign active = ~en_sync[1];
	assign rise = active & clk_sync[1] & ~clk_hist;
	assign fall = active & ~clk_sync[1] & clk_hist;

	// ----------------------------------------------------------------
	// Shift in and decode
	// ----------------------------------------------------------------
	logic [4:0] count;
	logic [23:0] shift_in;
	logic rd_pend;

	always_ff @(posedge ref_clk) begin
		if (reset || !active) begin
			count <= 5'h00;
			rd_pend <= 1'b0;
		end else if (rise) begin
			if (count != amc_pkg::FRAME_BITS) begin
				count <= count + 5'h01;
			end
			if (count == amc_pkg::HEADER_BITS - 5'h01) begin
				rd_pend <= shift_in[6];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			shift_in <= 24'h000000;
		end else if (rise) begin
			shift_in <= {shift_in[22:0], sdi_sync[1]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			bus.wr_stb <= 1'b0;
			bus.addr <= 7'h00;
			bus.wdata <= 16'h0000;
		end else begin
			bus.wr_stb <= rise && count == amc_pkg::FRAME_BITS - 5'h01 && !shift_in[22];
			if (rise && count == amc_pkg::HEADER_BITS - 5'h01) begin
				bus.addr <= {shift_in[5:0], sdi_sync[1]};
			end
			if (rise && count == amc_pkg::FRAME_BITS - 5'h01) begin
				bus.wdata <= {shift_in[14:0], sdi_sync[1]};
			end
		end
	end

	// ----------------------------------------------------------------
	// Read data out, changed on the falling serial edge
	// ----------------------------------------------------------------
	logic [15:0] shift_out;

	always_ff @(posedge ref_clk) begin
		if (reset || !active) begin
			shift_out <= 16'h0000;
			sif_sdo <= 1'b0;
			sif_sdo_oe <= 1'b0;
		end else begin
			sif_sdo_oe <= rd_pend && count >= amc_pkg::HEADER_BITS;
			if (fall && rd_pend && count == amc_pkg::HEADER_BITS) begin
				sif_sdo <= bus.rdata[15];
				shift_out <= {bus.rdata[14:0], 1'b0};
			end else if (fall && rd_pend && count > amc_pkg::HEADER_BITS) begin
				sif_sdo <= shift_out[15];
				shift_out <= {shift_out[14:0], 1'b0};
			end
		end
	end

endmodule : amc_serial_port

`default_nettype wire

// ===== testbench/amc_alarm_mask_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module amc_chk #(
	parameter int DATA_W = 64,
	parameter int LANES = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Watched ports
	input wire logic tx_enable_pin,
	input wire logic tx_gate,
	input wire logic [DATA_W-1:0] sample_in,
	input wire logic [LANES-1:0] lane_fifo_error,
	input wire logic [DATA_W-1:0] sample_out,
	input wire logic [3:0] current_scale,
	input wire logic sif_en_n,
	input wire logic [47:0] alarm_in,
	input wire logic [47:0] alarm_reported,
	input wire logic alarm_out
);
	default clocking dcb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	a_scale_after_reset: assert property ($fell(reset) |-> current_scale == 4'hF && !tx_gate)
		else $error("scale or gate wrong after reset");
	// Writes land inside a frame, so a long idle enable must leave the scale alone.
	a_scale_idle_stable: assert property ((sif_en_n[*8] ##0 !$past(reset)) |=> $stable(current_scale))
		else $error("scale changed outside a frame");
	a_gate_follows_pin: assert property (tx_enable_pin[*3] |=> tx_gate)
		else $error("gate low while pin held high");
	a_sample_pass: assert property (!$past(reset) && !(|$past(lane_fifo_error))
		|-> sample_out == $past(sample_in))
		else $error("sample not passed without fifo error");
	a_sample_blank_form: assert property (!$past(reset)
		|-> sample_out == '0 || sample_out == $past(sample_in))
		else $error("sample neither zero nor passed");
	a_alarm_merge: assert property (alarm_out == |alarm_reported)
		else $error("merged alarm disagrees with reported");
	a_alarm_subset: assert property (!$past(reset) |-> (alarm_reported & ~$past(alarm_in)) == '0)
		else $error("alarm reported without a source");
	a_alarm_quiet: assert property (alarm_in == '0 |=> alarm_reported == '0 ##0 !alarm_out)
		else $error("alarm reported while sources quiet");
endmodule : amc_chk

bind amc_alarm_mask_top amc_chk #(.DATA_W(DATA_W), .LANES(LANES)) u_chk (
	.ref_clk(ref_clk), .reset(reset), .tx_enable_pin(tx_enable_pin), .tx_gate(tx_gate),
	.sample_in(sample_in), .lane_fifo_error(lane_fifo_error), .sample_out(sample_out),
	.current_scale(current_scale), .sif_en_n(sif_en_n), .alarm_in(alarm_in),
	.alarm_reported(alarm_reported), .alarm_out(alarm_out)
);

`default_nettype wire

// ===== testbench/alarm_mask_output_control_tb.sv
`timescale 1ns/100ps
`default_nettype none

module alarm_mask_output_control_tb;
	localparam logic [47:0] SUP_MASK = 48'h7BDEFF0FA5F0;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic sif_clk = 1'b0;
	logic sif_sdi = 1'b0;
	logic sif_en_n = 1'b1;
	logic sif_sdo;
	logic sif_sdo_oe;
	logic tx_enable_pin = 1'b0;
	logic tx_gate;
	logic [63:0] sample_in = 64'h0123456789ABCDEF;
	logic [7:0] lane_fifo_error = 8'h00;
	logic [63:0] sample_out;
	logic [3:0] current_scale;
	logic [47:0] alarm_in = 48'h000000000000;
	logic [47:0] alarm_reported;
	logic alarm_out;
	int n_fail = 0;
	int checks_done = 0;

	always #10 ref_clk = ~ref_clk;

	amc_alarm_mask_top u_dut (
		.ref_clk(ref_clk), .reset(reset), .sif_clk(sif_clk), .sif_sdi(sif_sdi),
		.sif_en_n(sif_en_n), .sif_sdo(sif_sdo), .sif_sdo_oe(sif_sdo_oe),
		.tx_enable_pin(tx_enable_pin), .tx_gate(tx_gate), .sample_in(sample_in),
		.lane_fifo_error(lane_fifo_error), .sample_out(sample_out),
		.current_scale(current_scale), .alarm_in(alarm_in),
		.alarm_reported(alarm_reported), .alarm_out(alarm_out)
	);

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : step

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Half periods of eight cycles keep the serial clock well below a quarter of ref_clk.
	task automatic xfer(input logic is_rd, input logic [6:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic oe);
		logic [23:0] f;
		f = {is_rd, a, d};
		q = 16'h0000;
		oe = 1'b0;
		sif_en_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			step(8);
			sif_clk <= 1'b0;
			sif_sdi <= f[i];
			step(8);
			if (i < 16) q[i] = sif_sdo;
			if (i == 0) oe = sif_sdo_oe;
			sif_clk <= 1'b1;
		end
		step(8);
		sif_en_n <= 1'b1;
		sif_clk <= 1'b0;
		step(8);
	endtask : xfer

	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] q;
		logic oe;
		xfer(1'b0, a, d, q, oe);
		chk("sdo_oe on write", 64'h0, {63'h0, oe});
	endtask : wr

	task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
		logic [15:0] q;
		logic oe;
		xfer(1'b1, a, 16'h0000, q, oe);
		chk("sdo_oe on read", 64'h1, {63'h0, oe});
		chk($sformatf("reg %h", a), {48'h0, exp}, {48'h0, q});
	endtask : rdc

	task automatic give_verdict();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict

	initial begin
		step(20000);
		n_fail++;
		give_verdict();
	end

	initial begin
		step(4);
		reset <= 1'b0;
		step(2);
		rdc(7'h03, amc_pkg::RST_OUTPUT_CONTROL);
		rdc(7'h04, amc_pkg::RST_ALARM_SUPPRESS_LOW);
		rdc(7'h05, 16'hFFFF);
		rdc(7'h06, 16'hFFFF);
		chk("scale", 64'hF, {60'h0, current_scale});
		lane_fifo_error <= 8'h10;
		step(3);
		chk("blank", 64'h0, sample_out);
		chk("gate", 64'h0, {63'h0, tx_gate});
		wr(7'h03, 16'h1234);
		rdc(7'h03, 16'h1300);
		chk("scale", 64'h1, {60'h0, current_scale});
		chk("pass", sample_in, sample_out);
		tx_enable_pin <= 1'b1;
		step(5);
		chk("gate", 64'h1, {63'h0, tx_gate});
		tx_enable_pin <= 1'b0;
		step(5);
		chk("gate", 64'h0, {63'h0, tx_gate});
		wr(7'h03, 16'h0CFF);
		rdc(7'h03, 16'h0381);
		chk("scale", 64'h0, {60'h0, current_scale});
		chk("gate", 64'h1, {63'h0, tx_gate});
		chk("blank", 64'h0, sample_out);
		wr(7'h04, 16'h5A0F);
		wr(7'h05, 16'h0000);
		wr(7'h06, 16'h8421);
		rdc(7'h05, 16'h00F0);
		for (int i = 0; i < 48; i++) begin
			alarm_in <= 48'h1 << i;
			step(2);
			chk("reported", {16'h0, (48'h1 << i) & SUP_MASK}, {16'h0, alarm_reported});
			chk("merged", {63'h0, |((48'h1 << i) & SUP_MASK)}, {63'h0, alarm_out});
		end
		wr(7'h02, 16'h0001);
		rdc(7'h02, 16'h0000);
		rdc(7'h03, amc_pkg::RST_OUTPUT_CONTROL);
		rdc(7'h04, amc_pkg::RST_ALARM_SUPPRESS_LOW);
		rdc(7'h05, amc_pkg::RST_ALARM_SUPPRESS_MID);
		rdc(7'h06, amc_pkg::RST_ALARM_SUPPRESS_HIGH);
		chk("scale", 64'hF, {60'h0, current_scale});
		give_verdict();
	end
endmodule : alarm_mask_output_control_tb

`default_nettype wire
